/* src/hidw_iso_writeback.sv */
// iso descriptor write-back sequencer with axi4-lite access to the descriptor
`timescale 1ns/10ps
module hidw_iso_writeback
  import hidw_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic uf_done,
  input wire logic [2:0] uf_idx,
  input wire logic uf_dir_in,
  input wire logic [11:0] uf_rx_count,
  input wire logic uf_txn_err,
  input wire logic uf_babble,
  input wire logic uf_underrun,
  input wire logic [7:0] frame_num,
  input wire logic fatal_err,
  output logic wb_busy,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import hidw_pkg::*;

  // all state of the block
  typedef struct packed {
    hidw_state_t st;
    logic [2:0] ptr;            // word pointer of the read/write sweep
    logic [7:0][31:0] dbuf;     // working copy of the descriptor
    logic [2:0] ev_idx;         // captured microframe number
    logic [11:0] ev_cnt;        // captured received byte count
    logic [2:0] ev_res;         // captured result field
    logic ev_fatal;             // event is a fatal error
    logic rd_err;               // pending read hit an unmapped address
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic busy;
  } hidw_regs_t;

  hidw_regs_t cur_ff;  // registered state
  hidw_regs_t nxt_st;  // next state

  // memory port controls
  logic mem_we;
  logic [3:0] mem_be;
  logic [2:0] mem_waddr;
  logic [31:0] mem_wdata;
  logic mem_re;
  logic [2:0] mem_raddr;
  logic [31:0] mem_rdata;

  // true when a byte address falls inside the descriptor
  function automatic logic is_mapped(input logic [31:0] addr);
    return (addr < MAP_END);
  endfunction

  // drops a 12-bit count into the 96-bit count area of the three top words
  function automatic logic [95:0] put_count(input logic [95:0] area, input logic [2:0] idx,
                                            input logic [11:0] cnt);
    logic [95:0] r;
    r = area;
    r[CNT_W*idx +: CNT_W] = cnt;
    return r;
  endfunction

  // descriptor store
  hidw_desc_mem u_mem (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .wr_en(mem_we),
    .wr_be(mem_be),
    .wr_addr(mem_waddr),
    .wr_data(mem_wdata),
    .rd_en(mem_re),
    .rd_addr(mem_raddr),
    .rd_data(mem_rdata)
  );

  // memory port steering: sequencer sweep or bus access
  always_comb begin
    mem_we = 1'b0;
    mem_be = BE_ALL;
    mem_waddr = cur_ff.ptr;
    mem_wdata = cur_ff.dbuf[cur_ff.ptr];
    mem_re = 1'b0;
    mem_raddr = cur_ff.ptr;
    if (cur_ff.st == S_WR) begin
      // write back the modified working copy
      mem_we = 1'b1;
    end else if (cur_ff.st == S_BRSP && cur_ff.awready) begin
      // bus write at its handshake, unmapped addresses write nothing
      mem_we = is_mapped(s_axi_awaddr);
      mem_be = s_axi_wstrb;
      mem_waddr = s_axi_awaddr[4:2];
      mem_wdata = s_axi_wdata;
    end
    if (cur_ff.st == S_RD) begin
      // sweep read
      mem_re = 1'b1;
    end else if (cur_ff.st == S_AXR && cur_ff.arready) begin
      // bus read at its handshake
      mem_re = 1'b1;
      mem_raddr = s_axi_araddr[4:2];
    end
  end

  // next-state logic
  always_comb begin
    logic [95:0] area;
    area = {cur_ff.dbuf[W_LAST], cur_ff.dbuf[W_LAST - 3'h1], cur_ff.dbuf[W_CNT_LO]};
    nxt_st = cur_ff;
    unique case (cur_ff.st)
      S_IDLE: begin
        if (uf_done || fatal_err) begin
          // descriptor events win over bus traffic
          nxt_st.ev_idx = uf_idx;
          nxt_st.ev_cnt = uf_rx_count;
          nxt_st.ev_fatal = fatal_err;
          // babble only counts on in, underrun only on out
          nxt_st.ev_res[RES_TXN_ERR] = uf_txn_err;
          nxt_st.ev_res[RES_BABBLE] = uf_babble & uf_dir_in;
          nxt_st.ev_res[RES_UNDERRUN] = uf_underrun & ~uf_dir_in;
          nxt_st.ptr = 3'h0;
          nxt_st.st = S_RD;
        end else if (s_axi_awvalid && s_axi_wvalid) begin
          // take address and data together
          nxt_st.awready = 1'b1;
          nxt_st.wready = 1'b1;
          nxt_st.st = S_BRSP;
        end else if (s_axi_arvalid) begin
          nxt_st.arready = 1'b1;
          nxt_st.st = S_AXR;
        end
      end
      S_RD: begin
        // read issued, data next cycle
        nxt_st.st = S_CAP;
      end
      S_CAP: begin
        // store the word just read
        nxt_st.dbuf[cur_ff.ptr] = mem_rdata;
        nxt_st.ptr = cur_ff.ptr + 3'h1;
        nxt_st.st = (cur_ff.ptr == W_LAST) ? S_MOD : S_RD;
      end
      S_MOD: begin
        nxt_st.ptr = 3'h0;
        if (!cur_ff.dbuf[W_CTRL][VALID_BIT]) begin
          // descriptor not active: nothing to record
          nxt_st.st = S_IDLE;
        end else if (cur_ff.ev_fatal) begin
          // fatal error retires the descriptor
          nxt_st.dbuf[W_CTRL][VALID_BIT] = 1'b0;
          nxt_st.st = S_WR;
        end else begin
          // result field of this microframe, uframe 7 in the top bits
          nxt_st.dbuf[W_STATUS][STATUS_LSB + STATUS_W*cur_ff.ev_idx +: STATUS_W] = cur_ff.ev_res;
          if (cur_ff.dbuf[W_STATUS][MASK_LSB + cur_ff.ev_idx] &&
              cur_ff.dbuf[W_FRAME][FRAME_LSB +: FRAME_W] == frame_num) begin
            // count lands at 12*idx of the area; uframe 5 straddles two words
            area = put_count(area, cur_ff.ev_idx, cur_ff.ev_cnt);
            nxt_st.dbuf[W_LAST] = area[95:64];
            nxt_st.dbuf[W_LAST - 3'h1] = area[63:32];
            nxt_st.dbuf[W_CNT_LO] = area[31:0];
          end
          if (cur_ff.ev_idx == LAST_UFRAME) begin
            // whole descriptor executed
            nxt_st.dbuf[W_CTRL][VALID_BIT] = 1'b0;
          end
          nxt_st.st = S_WR;
        end
      end
      S_WR: begin
        // one word written per cycle
        nxt_st.ptr = cur_ff.ptr + 3'h1;
        if (cur_ff.ptr == W_LAST) begin
          nxt_st.st = S_IDLE;
        end
      end
      S_AXR: begin
        if (cur_ff.arready) begin
          // address taken, memory read under way
          nxt_st.arready = 1'b0;
          nxt_st.rd_err = !is_mapped(s_axi_araddr);
        end else begin
          // unmapped reads return zero with an error
          nxt_st.rdata = cur_ff.rd_err ? RST_WORD : mem_rdata;
          nxt_st.rresp = cur_ff.rd_err ? RESP_SLVERR : RESP_OKAY;
          nxt_st.rvalid = 1'b1;
          nxt_st.st = S_RRSP;
        end
      end
      S_BRSP: begin
        if (cur_ff.awready) begin
          // write done at the handshake, answer next cycle
          nxt_st.awready = 1'b0;
          nxt_st.wready = 1'b0;
          nxt_st.bvalid = 1'b1;
          nxt_st.bresp = is_mapped(s_axi_awaddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
          nxt_st.bvalid = 1'b0;
          nxt_st.st = S_IDLE;
        end
      end
      S_RRSP: begin
        // hold the read answer until taken
        if (s_axi_rready) begin
          nxt_st.rvalid = 1'b0;
          nxt_st.st = S_IDLE;
        end
      end
    endcase
    nxt_st.busy = (nxt_st.st != S_IDLE);
  end

  // state register
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cur_ff <= '0;
      cur_ff.st <= S_IDLE;
      cur_ff.bresp <= RST_RESP;
      cur_ff.rresp <= RST_RESP;
      cur_ff.rdata <= RST_WORD;
    end else begin
      cur_ff <= nxt_st;
    end
  end

  // outputs straight from the state register
  assign wb_busy = cur_ff.busy;
  assign s_axi_awready = cur_ff.awready;
  assign s_axi_wready = cur_ff.wready;
  assign s_axi_bvalid = cur_ff.bvalid;
  assign s_axi_bresp = cur_ff.bresp;
  assign s_axi_arready = cur_ff.arready;
  assign s_axi_rvalid = cur_ff.rvalid;
  assign s_axi_rresp = cur_ff.rresp;
  assign s_axi_rdata = cur_ff.rdata;
endmodule

/* src/hidw_pkg.sv */
// package: constants, descriptor layout and states of the iso descriptor write-back block
package hidw_pkg;
  // descriptor geometry: eight 32-bit double-words, one aligned word each
  localparam int DESC_WORDS = 8;
  localparam int WORD_W = 32;
  localparam int WIDX_W = 3;
  // byte offsets of the descriptor double-words on the register bus
  localparam logic [31:0] OFF_DW0 = 32'h0000_0000;
  localparam logic [31:0] OFF_DW2 = 32'h0000_0008;
  localparam logic [31:0] OFF_DW4 = 32'h0000_0010;
  localparam logic [31:0] OFF_DW5 = 32'h0000_0014;
  localparam logic [31:0] OFF_DW7 = 32'h0000_001c;
  localparam logic [31:0] MAP_END = 32'h0000_0020;
  // word indexes derived from the offsets
  localparam logic [2:0] W_CTRL = OFF_DW0[4:2];
  localparam logic [2:0] W_FRAME = OFF_DW2[4:2];
  localparam logic [2:0] W_STATUS = OFF_DW4[4:2];
  localparam logic [2:0] W_CNT_LO = OFF_DW5[4:2];
  localparam logic [2:0] W_LAST = OFF_DW7[4:2];
  // field positions
  localparam int VALID_BIT = 0;
  localparam int FRAME_LSB = 0;
  localparam int FRAME_W = 8;
  localparam int MASK_LSB = 0;
  localparam int STATUS_LSB = 8;
  localparam int STATUS_W = 3;
  localparam int CNT_W = 12;
  localparam int CNT_AREA_W = 96;
  // status field bit meanings
  localparam int RES_TXN_ERR = 0;
  localparam int RES_BABBLE = 1;
  localparam int RES_UNDERRUN = 2;
  // last microframe of a descriptor
  localparam logic [2:0] LAST_UFRAME = 3'h7;
  // reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [1:0] RST_RESP = 2'h0;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [3:0] BE_ALL = 4'hf;

  // sequencer states
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_RD = 3'b001,
    S_CAP = 3'b010,
    S_MOD = 3'b011,
    S_WR = 3'b100,
    S_AXR = 3'b101,
    S_BRSP = 3'b110,
    S_RRSP = 3'b111
  } hidw_state_t;
endpackage

/* src/hidw_desc_mem.sv */
// descriptor store: 8 x 32 words, one write port with byte enables, registered read port
`timescale 1ns/10ps
module hidw_desc_mem
  import hidw_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic wr_en,
  input wire logic [3:0] wr_be,
  input wire logic [2:0] wr_addr,
  input wire logic [31:0] wr_data,
  input wire logic rd_en,
  input wire logic [2:0] rd_addr,
  output logic [31:0] rd_data
);
  // storage array, contents undefined until software writes it
  logic [31:0] mem_q [DESC_WORDS];

  // byte-enabled write
  always_ff @(posedge clk_sys) begin
    for (int b = 0; b < 4; b++) begin
      if (wr_en && wr_be[b]) begin
        mem_q[wr_addr][8*b +: 8] <= wr_data[8*b +: 8];
      end
    end
  end

  // read data come out of a register one cycle after rd_en
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rd_data <= RST_WORD;
    end else if (rd_en) begin
      rd_data <= mem_q[rd_addr];
    end
  end
endmodule

/* test/hidw_iso_writeback_monitor.sv */
// checker of sweep and bus timing at the write-back block ports
`timescale 1ns/10ps
module hidw_wb_monitor (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic uf_done,
  input wire logic fatal_err,
  input wire logic wb_busy,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // an event taken while the block is idle
  sequence s_take;
    !wb_busy && (uf_done || fatal_err);
  endsequence
  // read, modify and write-back phases, then idle again
  sequence s_sweep;
    wb_busy[*8] ##[10:18] !wb_busy;
  endsequence
  a_busy_rise: assert property (s_take |=> wb_busy) else $error("busy did not rise");
  a_sweep_span: assert property (s_take |=> s_sweep) else $error("sweep length wrong");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
    else $error("no write response");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid)
    else $error("no read data");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_ready_pair: assert property (s_axi_awready |-> s_axi_wready) else $error("readies apart");
  a_bvalid_ends: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
endmodule
bind hidw_iso_writeback hidw_wb_monitor mon_u (.clk_sys, .sys_rst, .uf_done, .fatal_err, .wb_busy,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);

/* test/hidw_iso_endpoint.sv */
// model of the iso endpoint side: reports the end of each microframe
`timescale 1ns/10ps
module hidw_iso_endpoint (
  input wire logic clk_sys,
  input wire logic wb_busy,
  output logic uf_done,
  output logic [2:0] uf_idx,
  output logic uf_dir_in,
  output logic [11:0] uf_rx_count,
  output logic uf_txn_err,
  output logic uf_babble,
  output logic uf_underrun
);
  initial {uf_done, uf_idx, uf_dir_in, uf_rx_count, uf_txn_err, uf_babble, uf_underrun} = '0;
  // one microframe result, offered only while idle, then wait out the sweep
  task automatic finish_uframe(input logic [2:0] k, input logic din, input logic [11:0] cnt, input logic [2:0] f);
    @(posedge clk_sys);
    while (wb_busy) @(posedge clk_sys);
    uf_done <= 1'b1;
    uf_idx <= k;
    uf_dir_in <= din;
    uf_rx_count <= cnt;
    {uf_underrun, uf_babble, uf_txn_err} <= f;
    @(posedge clk_sys);
    uf_done <= 1'b0;
    // released count and flag lines do not keep their value
    uf_rx_count <= ~cnt;
    {uf_underrun, uf_babble, uf_txn_err} <= ~f;
    @(posedge clk_sys);
    while (wb_busy) @(posedge clk_sys);
  endtask
endmodule

/* test/hidw_iso_writeback_bench.sv */
// bench: fills a descriptor over the bus, runs microframes, reads results back
`timescale 1ns/10ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin miscompares++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module hidw_iso_writeback_bench;
  import hidw_pkg::*;
  logic clk_sys = 0, sys_rst = 1, fatal_err = 0;
  logic [7:0] frame_num = 8'h5a;
  logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [3:0] s_axi_wstrb = BE_ALL;
  wire logic uf_done, uf_dir_in, uf_txn_err, uf_babble, uf_underrun, wb_busy;
  wire logic [2:0] uf_idx;
  wire logic [11:0] uf_rx_count;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  int miscompares = 0, check_count = 0, cyc = 0;
  logic [31:0] rd, exp_st;
  logic [1:0] rsp;
  logic [95:0] area;
  logic [2:0] res;
  int resp_lag = 0;  // edges before bready or rready rises, 0 raises it with the request
  always #5 clk_sys = ~clk_sys;
  hidw_iso_writeback dut_u (.clk_sys, .sys_rst, .uf_done, .uf_idx, .uf_dir_in, .uf_rx_count, .uf_txn_err,
    .uf_babble, .uf_underrun, .frame_num, .fatal_err, .wb_busy, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  hidw_iso_endpoint ep_u (.clk_sys, .wb_busy, .uf_done, .uf_idx, .uf_dir_in, .uf_rx_count, .uf_txn_err,
    .uf_babble, .uf_underrun);
  // verdict and end of run
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // cuts a hang short
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      end_of_test();
    end
  end
  // bus write: address and data offered together, each released when taken; bready may come late
  task automatic axw(input logic [31:0] a, input logic [31:0] d);
    logic awp, wp, bp;
    int n;
    awp = 1; wp = 1; bp = 1; n = 0;
    @(posedge clk_sys);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= (resp_lag == 0);
    while (bp) begin
      @(posedge clk_sys);
      n++;
      if (awp && s_axi_awready) begin awp = 0; s_axi_awvalid <= 0; end
      if (wp && s_axi_wready) begin wp = 0; s_axi_wvalid <= 0; end
      // response taken only at an edge where bvalid and bready both stand
      if (s_axi_bvalid && s_axi_bready) begin bp = 0; s_axi_bready <= 0; rsp = s_axi_bresp; end
      else if (n == resp_lag) s_axi_bready <= 1;
    end
  endtask
  // bus read: data and response taken at the rvalid and rready edge; rready may come late
  task automatic axr(input logic [31:0] a);
    logic ap, rp;
    int n;
    ap = 1; rp = 1; n = 0;
    @(posedge clk_sys);
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= (resp_lag == 0);
    while (rp) begin
      @(posedge clk_sys);
      n++;
      if (ap && s_axi_arready) begin ap = 0; s_axi_arvalid <= 0; end
      if (s_axi_rvalid && s_axi_rready) begin rp = 0; s_axi_rready <= 0; rd = s_axi_rdata; rsp = s_axi_rresp; end
      else if (n == resp_lag) s_axi_rready <= 1;
    end
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    sys_rst <= 0;
    // full descriptor: uframes 2,3,4,5,7 active, 6 not; uframe 2 straddles two words
    for (int i = 0; i < 8; i++) axw(4 * i, 32'h0);
    axw(OFF_DW2, 32'h5a);
    axw(OFF_DW4, 32'hbc);
    axw(OFF_DW0, 32'h1);
    area = '0;
    exp_st = 32'hbc;
    for (int k = 2; k < 8; k++) begin
      res = 3'((k * 3) % 8);
      ep_u.finish_uframe(3'(k), k[0], {4'(k), 8'hc5}, res);
      if (k != 6) area[12 * k +: 12] = {4'(k), 8'hc5};
      exp_st[STATUS_LSB + 3 * k +: 3] = res & (k[0] ? 3'b011 : 3'b101);
    end
    axr(OFF_DW7); `CHK(rd, area[95:64])
    axr(32'h18); `CHK(rd, area[63:32])
    axr(OFF_DW5); `CHK({rsp, rd}, {RESP_OKAY, area[31:0]})
    axr(OFF_DW4); `CHK(rd, exp_st)
    axr(OFF_DW0); `CHK(rd, 32'h0)
    $display("test counts and results done");
    // wrong frame: count kept, result still written
    axw(OFF_DW0, 32'h1);
    frame_num <= 8'h5b;
    ep_u.finish_uframe(3'h4, 1'b0, 12'h0f0, 3'b001);
    exp_st[20 +: 3] = 3'b001;
    axr(32'h18); `CHK(rd, area[63:32])
    axr(OFF_DW4); `CHK(rd, exp_st)
    // fatal error clears valid, then an event on an invalid descriptor changes nothing
    @(posedge clk_sys); fatal_err <= 1;
    @(posedge clk_sys); fatal_err <= 0;
    axr(OFF_DW0); `CHK(rd, 32'h0)
    frame_num <= 8'h5a;
    ep_u.finish_uframe(3'h3, 1'b1, 12'h777, 3'b001);
    axr(32'h18); `CHK(rd, area[63:32])
    axr(OFF_DW4); `CHK(rd, exp_st)
    $display("test frame match and valid done");
    // unmapped place
    axr(MAP_END); `CHK({rsp, rd}, {RESP_SLVERR, 32'h0})
    axw(32'h24, 32'h1); `CHK(rsp, RESP_SLVERR)
    // the refused write must not have reached word 1
    axr(32'h4); `CHK({rsp, rd}, {RESP_OKAY, 32'h0})
    $display("test unmapped done");
    // one byte lane only, answers taken late so that bvalid and rvalid must stand
    resp_lag = 6;
    s_axi_wstrb <= 4'h2;
    axw(32'h4, 32'hffff_ffff); `CHK(rsp, RESP_OKAY)
    s_axi_wstrb <= BE_ALL;
    axr(32'h4); `CHK({rsp, rd}, {RESP_OKAY, 32'h0000_ff00})
    resp_lag = 0;
    $display("test strobes and late ready done");
    end_of_test();
  end
endmodule
